// >>> rsec_pkg.sv
`default_nettype none
package rsec_pkg;
  // ****************************************************************
  // register indices, byte address is four times the index
  // ****************************************************************
  localparam logic [29:0] IDX_TIMEOUT_CFG = 30'hdf12;
  localparam logic [29:0] IDX_EXIT_CFG = 30'hdf13;
  localparam logic [29:0] IDX_WAKE_PERIOD = 30'hdf30;
  localparam logic [29:0] IDX_WAKE_RES = 30'hdf31;
  localparam logic [29:0] IDX_STATUS = 30'hdf32;
  localparam logic [29:0] IDX_TIMEOUT_US = 30'hdf33;

  // field positions inside radio_exit_state_config
  localparam int CCA_LSB = 4;
  localparam int AFTER_RX_LSB = 2;
  localparam int AFTER_TX_LSB = 0;

  // reset values
  localparam logic [5:0] EXIT_CFG_RST = 6'h30;
  localparam logic [2:0] TIMEOUT_SEL_RST = 3'h7;
  localparam logic [15:0] WAKE_PERIOD_RST = 16'h0000;
  localparam logic [1:0] WAKE_RES_RST = 2'h0;

  // ****************************************************************
  // codes
  // ****************************************************************
  localparam logic [2:0] TIMEOUT_OFF = 3'h7;
  localparam logic [1:0] CCA_ALWAYS = 2'h0;
  localparam logic [1:0] CCA_RSSI = 2'h1;
  localparam logic [1:0] CCA_NO_PKT = 2'h2;
  localparam logic [1:0] CCA_BOTH = 2'h3;
  localparam logic [1:0] NEXT_IDLE = 2'h0;
  localparam logic [1:0] NEXT_FSTX = 2'h1;
  localparam logic [1:0] NEXT_TX = 2'h2;
  localparam logic [1:0] NEXT_RX = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ****************************************************************
  // timing: coefficient c = COEF_SCALE*k/208 per select step halved
  // ****************************************************************
  localparam logic [9:0] COEF_SCALE = 10'h2ee;
  localparam int COEF_SHIFT = 3;
  localparam int REF_MHZ = 26;
  localparam int CLK_PERIOD_NS = 100;
  localparam int NS_PER_US = 1000;
  localparam int CLK_PER_US = (NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    RSEC_IDLE = 2'b00,
    RSEC_RX = 2'b01,
    RSEC_FSTX = 2'b11,
    RSEC_TX = 2'b10
  } rsec_state_e;

  // resolution multiplier for the top coefficient row
  function automatic logic [3:0] rsec_coef_k(input logic [1:0] res);
    unique case (res)
      2'h0: rsec_coef_k = 4'h1;
      2'h1: rsec_coef_k = 4'h5;
      2'h2: rsec_coef_k = 4'h9;
      2'h3: rsec_coef_k = 4'hd;
    endcase
  endfunction
endpackage
`default_nettype wire

// >>> rsec_rx_timer.sv
`timescale 1ns/100ps
`default_nettype none
module rsec_rx_timer
  import rsec_pkg::*;
#(
  parameter int TICKS_PER_US = CLK_PER_US,
  parameter int LIMIT_W = 30
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic stop,
  input wire logic enable,
  input wire logic [LIMIT_W-1:0] limit_us,
  // result
  output logic expired
);
  localparam int PRE_W = $clog2(TICKS_PER_US + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICKS_PER_US - 1);

  logic running_ff;
  logic expired_ff;
  logic [PRE_W-1:0] pre_ff;
  logic [LIMIT_W-1:0] us_ff;
  logic tick;
  logic done;

  // one microsecond tick and end of search window
  assign tick = running_ff && (pre_ff == PRE_LAST);
  assign done = tick && ((us_ff + LIMIT_W'(1)) >= limit_us);
  assign expired = expired_ff;

  // search window counter, restarted by each entry to receive
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      running_ff <= 1'b0;
      pre_ff <= '0;
      us_ff <= '0;
    end else if (start) begin
      running_ff <= enable; // RULE7
      pre_ff <= '0;
      us_ff <= '0;
    end else if (stop || done) begin
      running_ff <= 1'b0;
    end else if (tick) begin
      pre_ff <= '0;
      us_ff <= us_ff + LIMIT_W'(1); // RULE7
    end else if (running_ff) begin
      pre_ff <= pre_ff + PRE_W'(1);
    end
  end

  // one cycle pulse at the end of the window
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      expired_ff <= 1'b0;
    end else begin
      expired_ff <= done && !start && !stop; // RULE7
    end
  end

  timer_fires_a: assert property (@(posedge clk) disable iff (!rst_n)
    done && !start && !stop |=> expired) // RULE7
    else $error("timer did not fire at its limit");
endmodule // rsec_rx_timer
`default_nettype wire

// >>> rsec_top.sv
// Function
// [RULE1] timeout is period times coefficient times 26/ref
// [RULE2] coefficients halve per step, code 111 disables
// [RULE3] two-bit policy drives the clear channel flag
// [RULE4] after receive go to selected next state
// [RULE5] software avoids transmit exit with channel assessment
// [RULE6] after transmit go to selected next state
// [RULE7] select field bounds sync search in receive
`timescale 1ns/100ps
`default_nettype none
module rsec_top
  import rsec_pkg::*;
#(
  parameter int REF_FREQ_MHZ = REF_MHZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // radio events
  input wire logic rssi_below_thr,
  input wire logic packet_active,
  input wire logic packet_received,
  input wire logic packet_sent,
  input wire logic sync_found,
  input wire logic cmd_idle,
  input wire logic cmd_rx,
  input wire logic cmd_tx,
  // radio outputs
  output logic clear_channel_flag,
  output logic [1:0] radio_state,
  output logic preamble_restart,
  output logic rx_timeout,
  output logic [29:0] timeout_us
);
  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [29:0] addr_ff;
  logic wr_pend_ff;
  logic [5:0] exit_cfg_ff;
  logic [2:0] timeout_sel_ff;
  logic [15:0] wake_period_ff;
  logic [1:0] wake_res_ff;
  logic [29:0] timeout_us_ff;
  logic clear_channel_ff;
  logic preamble_ff;
  rsec_state_e state_ff;
  rsec_state_e nxt_state;
  logic [1:0] clear_channel_policy;
  logic [1:0] after_receive_state;
  logic [1:0] after_transmit_state;
  logic [31:0] nxt_timeout_num;
  logic [31:0] nxt_timeout_shr;
  logic addr_ok;
  logic any_cmd;
  logic rx_start;
  logic rx_stop;

  // index match of a word address
  function automatic logic reg_hit(input logic [29:0] a,
                                   input logic [29:0] idx);
    reg_hit = (a == idx);
  endfunction

  // code of an exit field to radio state
  function automatic rsec_state_e next_of(input logic [1:0] code);
    unique case (code)
      NEXT_IDLE: next_of = RSEC_IDLE;
      NEXT_FSTX: next_of = RSEC_FSTX;
      NEXT_TX: next_of = RSEC_TX;
      NEXT_RX: next_of = RSEC_RX;
    endcase
  endfunction

  // ****************************************************************
  // bus slave
  // ****************************************************************
  // zero wait state, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_ok = hsel && htrans[1] && hready;

  // address phase capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_ff <= '0;
      wr_pend_ff <= 1'b0;
    end else if (hready) begin
      addr_ff <= haddr[31:2];
      wr_pend_ff <= addr_ok && hwrite && (hsize == HSIZE_WORD);
    end
  end

  // exit state configuration register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      exit_cfg_ff <= EXIT_CFG_RST;
    end else if (wr_pend_ff && reg_hit(addr_ff, IDX_EXIT_CFG)) begin
      exit_cfg_ff <= hwdata[5:0];
    end
  end

  // receive timeout configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timeout_sel_ff <= TIMEOUT_SEL_RST;
      wake_period_ff <= WAKE_PERIOD_RST;
      wake_res_ff <= WAKE_RES_RST;
    end else if (wr_pend_ff) begin
      if (reg_hit(addr_ff, IDX_TIMEOUT_CFG)) begin
        timeout_sel_ff <= hwdata[2:0];
      end
      if (reg_hit(addr_ff, IDX_WAKE_PERIOD)) begin
        wake_period_ff <= hwdata[15:0];
      end
      if (reg_hit(addr_ff, IDX_WAKE_RES)) begin
        wake_res_ff <= hwdata[1:0];
      end
    end
  end

  // read data mux, unmapped reads as zero
  always_comb begin
    hrdata = '0;
    if (reg_hit(addr_ff, IDX_EXIT_CFG)) begin
      hrdata = {26'h0, exit_cfg_ff};
    end else if (reg_hit(addr_ff, IDX_TIMEOUT_CFG)) begin
      hrdata = {29'h0, timeout_sel_ff};
    end else if (reg_hit(addr_ff, IDX_WAKE_PERIOD)) begin
      hrdata = {16'h0000, wake_period_ff};
    end else if (reg_hit(addr_ff, IDX_WAKE_RES)) begin
      hrdata = {30'h0, wake_res_ff};
    end else if (reg_hit(addr_ff, IDX_STATUS)) begin
      hrdata = {28'h0000000, preamble_ff, clear_channel_ff, state_ff};
    end else if (reg_hit(addr_ff, IDX_TIMEOUT_US)) begin
      hrdata = {2'h0, timeout_us_ff};
    end
  end

  // ****************************************************************
  // field views
  // ****************************************************************
  assign clear_channel_policy = exit_cfg_ff[CCA_LSB +: 2];
  assign after_receive_state = exit_cfg_ff[AFTER_RX_LSB +: 2];
  assign after_transmit_state = exit_cfg_ff[AFTER_TX_LSB +: 2];

  // ****************************************************************
  // receive timeout in microseconds
  // ****************************************************************
  // period*750*k/(208*2^sel) *26/ref = period*750*k/(2^(sel+3)*ref)
  always_comb begin
    nxt_timeout_num = 32'(wake_period_ff) * 32'(COEF_SCALE)
                      * 32'(rsec_coef_k(wake_res_ff)); // RULE1
    nxt_timeout_shr = nxt_timeout_num >> (timeout_sel_ff + COEF_SHIFT); // RULE2
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timeout_us_ff <= '0;
    end else begin
      timeout_us_ff <= 30'(nxt_timeout_shr / 32'(REF_FREQ_MHZ)); // RULE1
    end
  end
  assign timeout_us = timeout_us_ff;

  // ****************************************************************
  // clear channel flag
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clear_channel_ff <= 1'b1;
    end else begin
      unique case (clear_channel_policy) // RULE3
        CCA_ALWAYS: clear_channel_ff <= 1'b1;
        CCA_RSSI: clear_channel_ff <= rssi_below_thr;
        CCA_NO_PKT: clear_channel_ff <= !packet_active;
        CCA_BOTH: clear_channel_ff <= rssi_below_thr && !packet_active;
      endcase
    end
  end
  assign clear_channel_flag = clear_channel_ff;

  // ****************************************************************
  // radio state after packet end
  // ****************************************************************
  assign any_cmd = cmd_idle || cmd_rx || cmd_tx;

  always_comb begin
    nxt_state = state_ff;
    if (cmd_idle) begin
      nxt_state = RSEC_IDLE;
    end else if (cmd_rx) begin
      nxt_state = RSEC_RX;
    end else if (cmd_tx) begin
      nxt_state = RSEC_TX;
    end else if (state_ff == RSEC_RX && packet_received) begin
      nxt_state = next_of(after_receive_state); // RULE4
    end else if (state_ff == RSEC_RX && rx_timeout) begin
      nxt_state = RSEC_IDLE; // RULE7
    end else if (state_ff == RSEC_TX && packet_sent) begin
      nxt_state = next_of(after_transmit_state); // RULE6
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= RSEC_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end
  assign radio_state = state_ff;

  // new preamble when transmit repeats
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      preamble_ff <= 1'b0;
    end else begin
      preamble_ff <= !any_cmd && state_ff == RSEC_TX && packet_sent
                     && after_transmit_state == NEXT_TX; // RULE6
    end
  end
  assign preamble_restart = preamble_ff;

  // ****************************************************************
  // sync search timer
  // ****************************************************************
  assign rx_start = nxt_state == RSEC_RX
                    && (state_ff != RSEC_RX || packet_received || cmd_rx);
  // a select of 111 written mid-search also cancels the running window
  assign rx_stop = sync_found || nxt_state != RSEC_RX
                   || timeout_sel_ff == TIMEOUT_OFF; // RULE2

  rsec_rx_timer #(
    .TICKS_PER_US(CLK_PER_US),
    .LIMIT_W(30)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(rx_start),
    .stop(rx_stop),
    .enable(timeout_sel_ff != TIMEOUT_OFF), // RULE2
    .limit_us(timeout_us_ff),
    .expired(rx_timeout)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  timeout_example_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
    (wake_period_ff == 16'd34666 && wake_res_ff == 2'h0
     && timeout_sel_ff == 3'h6) [*2] |-> timeout_us_ff == 30'd1953)
    else $error("receive timeout value wrong");

  timeout_off_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
    (timeout_sel_ff == TIMEOUT_OFF) [*2] |-> !rx_timeout)
    else $error("timeout fired while disabled");

  cca_rssi_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
    clear_channel_policy == CCA_RSSI
    |=> clear_channel_flag == $past(rssi_below_thr))
    else $error("clear flag ignores signal level");

  cca_both_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
    clear_channel_policy == CCA_BOTH
    |=> clear_channel_flag
        == ($past(rssi_below_thr) && !$past(packet_active)))
    else $error("clear flag combined policy wrong");

  after_rx_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
    state_ff == RSEC_RX && packet_received && !any_cmd
    && after_receive_state == NEXT_TX |=> state_ff == RSEC_TX)
    else $error("wrong state after receive");

  after_tx_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
    state_ff == RSEC_TX && packet_sent && !any_cmd
    && after_transmit_state == NEXT_RX |=> state_ff == RSEC_RX ##1 1)
    else $error("wrong state after transmit");

  tx_repeat_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
    $rose(preamble_restart) |-> state_ff == RSEC_TX
    && $past(after_transmit_state) == NEXT_TX)
    else $error("preamble restart without repeat");
endmodule // rsec_top
`default_nettype wire

// >>> dummy_end.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// >>> tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import rsec_pkg::*;
  // ********
  // signals
  // ********
  logic clk, rst_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, radio_state;
  logic [2:0] hsize;
  logic rssi_below_thr, packet_active, sync_found;
  logic clear_channel_flag, preamble_restart, rx_timeout;
  logic [29:0] timeout_us;
  logic [4:0] ev; // idle, rx, tx, received, sent pulses
  int miscompares, num_checks;
  rsec_state_e nxt_map [4];

  // ********
  // design
  // ********
  rsec_top rsec_top_i (
    .clk(clk),
    .rst_n(rst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .rssi_below_thr(rssi_below_thr),
    .packet_active(packet_active),
    .packet_received(ev[3]),
    .packet_sent(ev[4]),
    .sync_found(sync_found),
    .cmd_idle(ev[0]),
    .cmd_rx(ev[1]),
    .cmd_tx(ev[2]),
    .clear_channel_flag(clear_channel_flag),
    .radio_state(radio_state),
    .preamble_restart(preamble_restart),
    .rx_timeout(rx_timeout),
    .timeout_us(timeout_us)
  );

  // 10 mhz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ********
  // tasks
  // ********
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one ahb-lite single transfer, read data kept in rd
  task automatic bus(input logic [29:0] idx, input logic wr,
                     input logic [2:0] sz, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= sz;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [29:0] idx, input logic [31:0] d);
    bus(idx, 1'b1, HSIZE_WORD, d);
  endtask

  task automatic rchk(input logic [29:0] idx, input logic [31:0] exp);
    bus(idx, 1'b0, HSIZE_WORD, 32'h0);
    chk(rd, exp);
    chk({30'h0, hreadyout, hresp}, 32'h2);
  endtask

  // one-cycle event pulse
  task automatic pulse(input int n);
    @(posedge clk);
    ev <= 5'h01 << n;
    @(posedge clk);
    ev <= 5'h00;
  endtask

  task automatic end_sim;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end

  // ********
  // tests
  // ********
  initial begin
    int exp;
    int cnt;
    {rst_n, hsel, hwrite, packet_active} = 4'h0;
    rssi_below_thr = 1'b1;
    {haddr, hwdata, htrans, sync_found, ev} = '0;
    hsize = HSIZE_WORD;
    miscompares = 0;
    num_checks = 0;
    nxt_map = '{RSEC_IDLE, RSEC_FSTX, RSEC_TX, RSEC_RX};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    // reset values, refused and unmapped accesses
    rchk(IDX_EXIT_CFG, 32'(EXIT_CFG_RST));
    rchk(IDX_TIMEOUT_CFG, 32'h7);
    rchk(IDX_STATUS, 32'h4);
    rchk(IDX_TIMEOUT_US, 32'h0);
    rchk(30'h0000df20, 32'h0);
    bus(IDX_EXIT_CFG, 1'b1, 3'h0, 32'h3f);
    rchk(IDX_EXIT_CFG, 32'h30);
    wr(IDX_STATUS, 32'hf);
    rchk(IDX_STATUS, 32'h4);
    $display("test reset done");
    // timeout over selects 0 to 6 and every resolution
    wr(IDX_WAKE_PERIOD, 32'd34666);
    for (int r = 0; r < 4; r++) begin
      wr(IDX_WAKE_RES, r);
      for (int s = 0; s < 7; s++) begin
        wr(IDX_TIMEOUT_CFG, s);
        exp = (34666 * 750 * (4 * r + 1)) >> (s + 3);
        rchk(IDX_TIMEOUT_US, exp / 26);
        chk(timeout_us, exp / 26);
      end
    end
    $display("test timeout done");
    // clear channel policy over all input pairs
    for (int p = 0; p < 4; p++) begin
      wr(IDX_EXIT_CFG, p << CCA_LSB);
      for (int c = 0; c < 4; c++) begin
        rssi_below_thr <= c[0];
        packet_active <= c[1];
        repeat (2) @(posedge clk);
        exp = (p == 0) | (p == 1 & c[0]) | (p == 2 & !c[1]);
        exp = exp | (p == 3 & c[0] & !c[1]);
        chk(clear_channel_flag, exp);
      end
    end
    rssi_below_thr <= 1'b0;
    packet_active <= 1'b0;
    $display("test clear channel done");
    // next state after receive, timer disabled
    wr(IDX_TIMEOUT_CFG, 32'h7);
    for (int c = 0; c < 4; c++) begin
      wr(IDX_EXIT_CFG, c << AFTER_RX_LSB);
      pulse(1);
      pulse(3);
      @(negedge clk);
      chk(radio_state, nxt_map[c]);
      pulse(0);
    end
    $display("test after receive done");
    // next state after transmit, preamble restart on repeat
    for (int c = 0; c < 4; c++) begin
      wr(IDX_EXIT_CFG, c << AFTER_TX_LSB);
      pulse(2);
      pulse(4);
      @(negedge clk);
      chk(radio_state, nxt_map[c]);
      chk(preamble_restart, c == 2);
      pulse(0);
    end
    $display("test after transmit done");
    // sync search expiry, 5 us with period 100 and select 6
    wr(IDX_WAKE_PERIOD, 32'd100);
    wr(IDX_WAKE_RES, 32'h0);
    wr(IDX_TIMEOUT_CFG, 32'h6);
    exp = (((100 * 750) >> 9) / 26) * CLK_PER_US;
    pulse(1);
    cnt = 0;
    while (rx_timeout !== 1'b1 && cnt < 1000) begin
      @(negedge clk);
      cnt++;
    end
    chk(cnt >= exp - 2 && cnt <= exp + 3, 1'b1);
    @(negedge clk);
    chk(radio_state, RSEC_IDLE);
    // sync found stops the search, select 7 never expires
    for (int m = 0; m < 2; m++) begin
      pulse(0);
      wr(IDX_TIMEOUT_CFG, m ? 32'h7 : 32'h6);
      pulse(1);
      sync_found <= !m;
      cnt = 0;
      repeat (150) begin
        @(negedge clk);
        cnt += (rx_timeout !== 1'b0);
      end
      chk(cnt, 0);
      chk(radio_state, RSEC_RX);
      @(posedge clk);
      sync_found <= 1'b0;
    end
    $display("test sync search done");
    end_sim();
  end
endmodule // tb
`default_nettype wire
